// *** logic/mss_pkg.sv ***
// constants and types for the multistep speed sequencer
// Summary of operation
// - mode zero disables automatic program operation
// - mode 1: one cycle, resume interrupted stage
// - mode 2: repeat cycles, resume reached stage
// - mode 3: one cycle, hold last, resume
// - mode 4: one cycle, restart at stage 0
// - mode 5: repeat cycles, restart at stage 0
// - mode 6: one cycle, hold, restart stage 0
// - stage frequency, time, direction from tables
// - wobble or pid forces program operation off
// - program operation ignores external speed selects
// - stage frequency limited to 599.00 Hz
// - sixteen acceleration times, up to 6000.0 s
// - sixteen deceleration times, up to 6000.0 s
// - ramp time from active speed command
// - per-stage times only when selector is one
// - ramp time = time * delta / max frequency
// - program operation ramps with first time set
// - all stage times zero means inactive
package mss_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h01;
  localparam logic [7:0] MAXF_OFS = 8'h02;
  localparam logic [7:0] ACC1_OFS = 8'h03;
  localparam logic [7:0] DEC1_OFS = 8'h04;
  localparam logic [7:0] RAMP_OFS = 8'h05;
  localparam logic [3:0] FREQ_GRP = 4'h1;
  localparam logic [3:0] TIME_GRP = 4'h2;
  localparam logic [3:0] DIR_GRP = 4'h3;
  localparam logic [3:0] ACC_GRP = 4'h4;
  localparam logic [3:0] DEC_GRP = 4'h5;
  // control fields
  localparam int MODE_LSB = 0;
  localparam int INDEP_BIT = 4;
  localparam int WOBBLE_BIT = 5;
  localparam int PID_BIT = 6;
  // status fields
  localparam int STAGE_LSB = 0;
  localparam int AUTO_BIT = 4;
  localparam int ST_LSB = 8;
  localparam int DIR_LSB = 12;
  // reset values and limits (0.01 Hz and 0.1 s units)
  localparam logic [15:0] MAXF_RST = 16'h1770;
  localparam logic [15:0] TIME1_RST = 16'h0064;
  localparam logic [15:0] FREQ_LIM = 16'he9fc;
  localparam logic [15:0] TIME_LIM = 16'hea60;
  // stage timer base
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // direction codes
  localparam logic [1:0] DIR_STOP = 2'h0;
  localparam logic [1:0] DIR_FWD = 2'h1;
  localparam logic [1:0] DIR_REV = 2'h2;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_HOLD = 2'b10,
    SEQ_DONE = 2'b11
  } mss_seq_t;
endpackage : mss_pkg

// *** logic/mss_tick.sv ***
// stage time base: one-cycle enable every CYC clocks while counting
`timescale 1ns/1ps
module mss_tick #(
  parameter int unsigned CYC = mss_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control and pulse
  input wire logic en,
  output logic tick
);
  localparam int CW = $clog2(CYC + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } mss_tick_st_t;
  mss_tick_st_t s, n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (!en) begin
      n.cnt = '0;
    end else if (s.cnt == CW'(CYC - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule : mss_tick

// *** logic/mss_div.sv ***
// serial restoring divider for ramp duration, 32 steps per result
`timescale 1ns/1ps
module mss_div #(
  parameter int NW = 32,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // request
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  // result
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);
  localparam int CW = $clog2(NW);
  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [NW-1:0] q;
    logic [DW:0] rem;
  } mss_div_st_t;
  mss_div_st_t s, n;
  logic [DW:0] sh;

  always_comb begin
    n = s;
    n.done = 1'b0;
    sh = {s.rem[DW-1:0], s.q[NW-1]};
    if (start && !s.busy) begin
      n.busy = 1'b1;
      n.cnt = '0;
      n.q = num;
      n.rem = '0;
    end else if (s.busy) begin
      if (sh >= {1'b0, den}) begin
        n.rem = sh - {1'b0, den};
        n.q = {s.q[NW-2:0], 1'b1};
      end else begin
        n.rem = sh;
        n.q = {s.q[NW-2:0], 1'b0};
      end
      n.cnt = s.cnt + CW'(1);
      if (s.cnt == CW'(NW - 1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
  assign quot = s.q;

  a_div_latency: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (start && !busy) |-> ##33 done)
    else $error("ramp divider did not finish in 33 cycles");
endmodule : mss_div

// *** logic/mss_top.sv ***
// automatic program sequencer with per-stage ramp time calculation
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module mss_top #(
  parameter int unsigned TICK_CYC = mss_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // run command and manual speed select
  input wire logic run,
  input wire logic [3:0] ms_sel,
  input wire logic [1:0] man_dir,
  // drive core feedback
  input wire logic [15:0] out_freq,
  // drive core commands
  output logic [15:0] freq_ref,
  output logic [1:0] dir,
  output logic auto_on,
  output logic [3:0] stage_idx,
  output logic [31:0] ramp_time,
  output logic ramp_accel,
  output logic ramp_valid
);
  typedef struct packed {
    mss_pkg::mss_seq_t st;
    logic [3:0] stage;
    logic [15:0] elapsed;
    logic [2:0] mode;
    logic indep;
    logic wobble;
    logic pid;
    logic [15:0] maxf;
    logic [15:0] acc1;
    logic [15:0] dec1;
    logic [15:0] freq_ref;
    logic [1:0] dir;
    logic go;
    logic accel;
    logic [15:0] tsel;
    logic [31:0] ramp_time;
    logic ramp_valid;
    logic [31:0] rdata;
  } mss_top_st_t;
  mss_top_st_t s, n;

  logic [15:0] freq_mem [16];
  logic [15:0] time_mem [16];
  logic [15:0] acc_mem [16];
  logic [15:0] dec_mem [16];
  logic [1:0] dir_mem [16];
  logic [15:0] time_nz;

  logic tick;
  logic div_busy;
  logic div_done;
  logic [31:0] quot;
  logic auto_en;
  logic adv;
  logic restart0;
  logic [15:0] cur_time;
  logic [15:0] diff;
  logic [31:0] num;

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  // stage tables, one entry per stage
  for (genvar i = 0; i < 16; i++) begin : g_ent
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        freq_mem[i] <= 16'h0;
        time_mem[i] <= 16'h0;
        acc_mem[i] <= mss_pkg::TIME1_RST;
        dec_mem[i] <= mss_pkg::TIME1_RST;
        dir_mem[i] <= mss_pkg::DIR_STOP;
      end else if (wr && addr[3:0] == 4'(i)) begin
        if (addr[7:4] == mss_pkg::FREQ_GRP) begin
          freq_mem[i] <= clamp(wdata[15:0], mss_pkg::FREQ_LIM);
        end
        if (addr[7:4] == mss_pkg::TIME_GRP) begin
          time_mem[i] <= clamp(wdata[15:0], mss_pkg::TIME_LIM);
        end
        if (addr[7:4] == mss_pkg::ACC_GRP) begin
          acc_mem[i] <= clamp(wdata[15:0], mss_pkg::TIME_LIM);
        end
        if (addr[7:4] == mss_pkg::DEC_GRP) begin
          dec_mem[i] <= clamp(wdata[15:0], mss_pkg::TIME_LIM);
        end
        if (addr[7:4] == mss_pkg::DIR_GRP && wdata[1:0] != 2'h3) begin
          dir_mem[i] <= wdata[1:0];
        end
      end
    end
    assign time_nz[i] = |time_mem[i];
  end

  mss_tick #(
    .CYC(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .en(s.st == mss_pkg::SEQ_RUN),
    .tick(tick)
  );

  // ramp duration: selected time * frequency step / max frequency
  assign diff = (s.freq_ref > out_freq) ? s.freq_ref - out_freq
                                        : out_freq - s.freq_ref;
  assign num = 32'(s.tsel) * 32'(diff);

  mss_div #(
    .NW(32),
    .DW(16)
  ) u_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(s.go),
    .num(num),
    .den(s.maxf),
    .busy(div_busy),
    .done(div_done),
    .quot(quot)
  );

  assign auto_en = (s.mode != 3'h0) && (s.mode <= 3'h6)
                   && !s.wobble && !s.pid
                   && (|time_nz);
  assign cur_time = time_mem[s.stage];
  assign adv = (s.st == mss_pkg::SEQ_RUN) && tick
               && (s.elapsed + 16'h1 >= cur_time);
  assign restart0 = (s.mode >= 3'h4);

  always_comb begin
    logic [15:0] tgt;
    logic [1:0] tdir;
    logic [3:0] sel;
    logic [31:0] rv;
    logic prog;
    tgt = 16'h0;
    tdir = mss_pkg::DIR_STOP;
    sel = 4'h0;
    rv = 32'h0;
    prog = 1'b0;
    n = s;
    n.ramp_valid = 1'b0;

    // control registers
    if (wr && addr == mss_pkg::CTRL_OFS) begin
      n.mode = wdata[mss_pkg::MODE_LSB +: 3];
      n.indep = wdata[mss_pkg::INDEP_BIT];
      n.wobble = wdata[mss_pkg::WOBBLE_BIT];
      n.pid = wdata[mss_pkg::PID_BIT];
    end
    if (wr && addr == mss_pkg::MAXF_OFS) begin
      n.maxf = wdata[15:0];
    end
    if (wr && addr == mss_pkg::ACC1_OFS) begin
      n.acc1 = clamp(wdata[15:0], mss_pkg::TIME_LIM);
    end
    if (wr && addr == mss_pkg::DEC1_OFS) begin
      n.dec1 = clamp(wdata[15:0], mss_pkg::TIME_LIM);
    end

    // program sequence
    unique case (s.st)
      mss_pkg::SEQ_IDLE: begin
        if (run && auto_en) begin
          n.st = mss_pkg::SEQ_RUN;
          n.elapsed = 16'h0;
          if (restart0) begin
            n.stage = 4'h0;
          end // otherwise resume stored stage
        end
      end
      mss_pkg::SEQ_RUN: begin
        if (!run || !auto_en) begin
          n.st = mss_pkg::SEQ_IDLE;
        end else if (adv) begin
          n.elapsed = 16'h0;
          if (s.stage != 4'hf) begin
            n.stage = s.stage + 4'h1;
          end else if (s.mode == 3'h1 || s.mode == 3'h4) begin
            n.st = mss_pkg::SEQ_DONE;
            n.stage = 4'h0;
          end else if (s.mode == 3'h2 || s.mode == 3'h5) begin
            n.stage = 4'h0;
          end else begin
            n.st = mss_pkg::SEQ_HOLD;
          end
        end else if (tick) begin
          n.elapsed = s.elapsed + 16'h1;
        end
      end
      mss_pkg::SEQ_HOLD: begin
        if (!run || !auto_en) begin
          n.st = mss_pkg::SEQ_IDLE;
        end
      end
      mss_pkg::SEQ_DONE: begin
        if (!run || !auto_en) begin
          n.st = mss_pkg::SEQ_IDLE;
        end
      end
    endcase

    // speed command: program tables or external selects
    prog = (n.st == mss_pkg::SEQ_RUN) || (n.st == mss_pkg::SEQ_HOLD);
    if (prog) begin
      tgt = freq_mem[n.stage];
      tdir = dir_mem[n.stage];
    end else if (auto_en) begin
      tgt = (n.st == mss_pkg::SEQ_DONE) ? 16'h0 : freq_mem[n.stage];
      tdir = mss_pkg::DIR_STOP;
    end else begin
      sel = ms_sel;
      tgt = freq_mem[sel];
      tdir = man_dir;
    end

    // ramp request on each change of the command
    if (s.go && !div_busy) begin
      n.go = 1'b0;
    end
    if (tgt != s.freq_ref || tdir != s.dir) begin
      n.go = 1'b1;
      n.accel = (tgt > out_freq);
      if (prog || !s.indep) begin
        n.tsel = n.accel ? s.acc1 : s.dec1;
      end else begin
        n.tsel = n.accel ? acc_mem[sel] : dec_mem[sel];
      end
    end
    n.freq_ref = tgt;
    n.dir = tdir;
    if (div_done) begin
      n.ramp_time = quot;
      n.ramp_valid = 1'b1;
    end

    // register read, data valid the cycle after the strobe
    if (addr[7:4] == 4'h0) begin
      if (addr == mss_pkg::CTRL_OFS) begin
        rv[mss_pkg::MODE_LSB +: 3] = s.mode;
        rv[mss_pkg::INDEP_BIT] = s.indep;
        rv[mss_pkg::WOBBLE_BIT] = s.wobble;
        rv[mss_pkg::PID_BIT] = s.pid;
      end
      if (addr == mss_pkg::STAT_OFS) begin
        rv[mss_pkg::STAGE_LSB +: 4] = s.stage;
        rv[mss_pkg::AUTO_BIT] = auto_en;
        rv[mss_pkg::ST_LSB +: 2] = s.st;
        rv[mss_pkg::DIR_LSB +: 2] = s.dir;
      end
      if (addr == mss_pkg::MAXF_OFS) begin
        rv[15:0] = s.maxf;
      end
      if (addr == mss_pkg::ACC1_OFS) begin
        rv[15:0] = s.acc1;
      end
      if (addr == mss_pkg::DEC1_OFS) begin
        rv[15:0] = s.dec1;
      end
      if (addr == mss_pkg::RAMP_OFS) begin
        rv = s.ramp_time;
      end
    end else if (addr[7:4] == mss_pkg::FREQ_GRP) begin
      rv[15:0] = freq_mem[addr[3:0]];
    end else if (addr[7:4] == mss_pkg::TIME_GRP) begin
      rv[15:0] = time_mem[addr[3:0]];
    end else if (addr[7:4] == mss_pkg::DIR_GRP) begin
      rv[1:0] = dir_mem[addr[3:0]];
    end else if (addr[7:4] == mss_pkg::ACC_GRP) begin
      rv[15:0] = acc_mem[addr[3:0]];
    end else if (addr[7:4] == mss_pkg::DEC_GRP) begin
      rv[15:0] = dec_mem[addr[3:0]];
    end
    n.rdata = rd ? rv : 32'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
      s.st <= mss_pkg::SEQ_IDLE;
      s.maxf <= mss_pkg::MAXF_RST;
      s.acc1 <= mss_pkg::TIME1_RST;
      s.dec1 <= mss_pkg::TIME1_RST;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign freq_ref = s.freq_ref;
  assign dir = s.dir;
  assign auto_on = (s.st == mss_pkg::SEQ_RUN) || (s.st == mss_pkg::SEQ_HOLD);
  assign stage_idx = s.stage;
  assign ramp_time = s.ramp_time;
  assign ramp_accel = s.accel;
  assign ramp_valid = s.ramp_valid;

  a_mode_zero_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s.mode == 3'h0) |=> (s.st == mss_pkg::SEQ_IDLE))
    else $error("program ran with mode zero");

  a_wobble_pid_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s.wobble || s.pid) |=> !auto_on)
    else $error("program ran with wobble or pid active");

  a_resume_stage: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s.st == mss_pkg::SEQ_IDLE && run && auto_en && !restart0)
    |=> (s.st == mss_pkg::SEQ_RUN && s.stage == $past(s.stage)))
    else $error("resume did not keep the interrupted stage");

  a_restart_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s.st == mss_pkg::SEQ_IDLE && run && auto_en && restart0)
    |=> (s.st == mss_pkg::SEQ_RUN && s.stage == 4'h0))
    else $error("restart did not begin at stage zero");

  a_cycle_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (adv && run && auto_en && s.stage == 4'hf
     && (s.mode == 3'h2 || s.mode == 3'h5))
    |=> (s.st == mss_pkg::SEQ_RUN && s.stage == 4'h0))
    else $error("continuous cycle did not wrap to stage zero");

  a_hold_last: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (adv && run && auto_en && s.stage == 4'hf
     && (s.mode == 3'h3 || s.mode == 3'h6) && !wr)
    |=> (s.st == mss_pkg::SEQ_HOLD && s.freq_ref == freq_mem[15]))
    else $error("last stage speed not held after cycle");

  a_stage_freq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (auto_on && !$past(wr)) |-> (s.freq_ref == freq_mem[s.stage]
     && s.dir == dir_mem[s.stage]))
    else $error("program output differs from stage table");

  a_stage_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s.st == mss_pkg::SEQ_RUN && $past(s.st) == mss_pkg::SEQ_RUN
     && s.stage != $past(s.stage))
    |-> ($past(s.elapsed) + 16'h1 >= $past(cur_time) && $past(tick)))
    else $error("stage advanced before its run time elapsed");
endmodule : mss_top

// *** tb/mss_ramp_model.sv ***
// ramp generator stand-in: output frequency chases the command
`timescale 1ns/1ps
module mss_ramp_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // command side
  input wire logic [15:0] freq_ref,
  input wire logic ramp_valid,
  input wire logic slow,
  // feedback
  output logic [15:0] out_freq
);
  logic go_r;

  // starts moving only after a ramp result, so the divider sees a fixed value
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      out_freq <= 16'h0000;
      go_r <= 1'b0;
    end else if (ramp_valid) begin
      go_r <= 1'b1;
    end else if (go_r) begin
      if (!slow || out_freq == freq_ref) begin
        out_freq <= freq_ref;
        go_r <= 1'b0;
      end else if (out_freq < freq_ref) begin
        out_freq <= out_freq + 16'h0001;
      end else begin
        out_freq <= out_freq - 16'h0001;
      end
    end
  end
endmodule : mss_ramp_model

// *** tb/testbench.sv ***
// self-checking bench for the program sequencer
`timescale 1ns/1ps
module testbench;
  localparam int TC = 4;
  logic sys_clk, rst_b, wr, rd, run, slow;
  logic ramp_accel, ramp_valid, auto_on;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, ramp_time, rv;
  logic [3:0] ms_sel, stage_idx;
  logic [1:0] man_dir, dir;
  logic [15:0] out_freq, freq_ref;
  int mismatches, check_count, n, k;

  mss_top #(.TICK_CYC(TC)) u_mss_top (.sys_clk(sys_clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .run(run), .ms_sel(ms_sel), .man_dir(man_dir), .out_freq(out_freq),
    .freq_ref(freq_ref), .dir(dir), .auto_on(auto_on),
    .stage_idx(stage_idx), .ramp_time(ramp_time),
    .ramp_accel(ramp_accel), .ramp_valid(ramp_valid));

  mss_ramp_model u_mss_ramp_model (.sys_clk(sys_clk), .rst_b(rst_b),
    .freq_ref(freq_ref), .ramp_valid(ramp_valid), .slow(slow),
    .out_freq(out_freq));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // stage tables used throughout
  function automatic logic [15:0] fv(int i);
    return 16'(256 * (i + 1));
  endfunction : fv
  function automatic logic [1:0] dv(int i);
    return (i % 2 == 1) ? 2'h2 : 2'h1;
  endfunction : dv
  function automatic logic [15:0] tv(int i);
    return (i == 7) ? 16'h0003 : 16'h0001;
  endfunction : tv

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic wait_stage(logic [3:0] s, output int c);
    c = 0;
    while (stage_idx !== s) begin
      cyc(1);
      c++;
      if (c > 200) begin
        check("stage wait", {28'h0, stage_idx}, {28'h0, s});
        end_sim();
      end
    end
  endtask : wait_stage

  task automatic wait_rv();
    int c;
    c = 0;
    while (ramp_valid !== 1'b1) begin
      cyc(1);
      c++;
      if (c > 100) begin
        check("ramp wait", 32'h0, 32'h1);
        end_sim();
      end
    end
  endtask : wait_rv

  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    run = 1'b0;
    ms_sel = 4'h0;
    man_dir = 2'h0;
    slow = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_reg(8'h02, rv);
    check("max freq", rv, 32'h1770);
    rd_reg(8'h41, rv);
    check("acc table", rv, 32'h64);
    rd_reg(8'h06, rv);
    check("unmapped", rv, 32'h0);
    check("reset freq", {16'h0, freq_ref}, 32'h0);
    wr_reg(8'h1f, 32'hffff);
    rd_reg(8'h1f, rv);
    check("freq limit", rv, 32'he9fc);
    wr_reg(8'h4f, 32'hffff);
    rd_reg(8'h4f, rv);
    check("acc limit", rv, 32'hea60);
    wr_reg(8'h5f, 32'hffff);
    rd_reg(8'h5f, rv);
    check("dec limit", rv, 32'hea60);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h10 + 8'(i), 32'(fv(i)));
      wr_reg(8'h20 + 8'(i), 32'(tv(i)));
      wr_reg(8'h30 + 8'(i), 32'(dv(i)));
    end
    wr_reg(8'h30, 32'h3);
    rd_reg(8'h30, rv);
    check("dir refused", rv, 32'(dv(0)));
    // manual speed select with per-stage and shared ramp times
    wr_reg(8'h42, 32'h4b);
    wr_reg(8'h00, 32'h10);
    cyc(100);
    @(posedge sys_clk);
    ms_sel <= 4'h2;
    man_dir <= 2'h2;
    run <= 1'b1;
    wait_rv();
    check("indep ramp", ramp_time, 32'(75 * 512 / 6000));
    check("accel flag", {31'h0, ramp_accel}, 32'h1);
    check("manual freq", {16'h0, freq_ref}, 32'(fv(2)));
    check("manual dir", {30'h0, dir}, 32'h2);
    check("manual auto", {31'h0, auto_on}, 32'h0);
    cyc(5);
    wr_reg(8'h04, 32'h1f4);
    wr_reg(8'h00, 32'h0);
    @(posedge sys_clk);
    ms_sel <= 4'h1;
    wait_rv();
    check("shared ramp", ramp_time, 32'(500 * 256 / 6000));
    check("decel flag", {31'h0, ramp_accel}, 32'h0);
    rd_reg(8'h05, rv);
    check("ramp reg", rv, 32'(500 * 256 / 6000));
    @(posedge sys_clk);
    run <= 1'b0;
    $display("test ramp done");
    for (int b = 0; b < 3; b++) begin
      k = b == 0 ? 'h21 : b == 1 ? 'h41 : 'h07;
      wr_reg(8'h00, 32'(k));
      rd_reg(8'h00, rv);
      check("ctrl read", rv, 32'(k));
      @(posedge sys_clk);
      run <= 1'b1;
      cyc(3);
      check("blocked auto", {31'h0, auto_on}, 32'h0);
      @(posedge sys_clk);
      run <= 1'b0;
    end
    $display("test blocking done");
    @(posedge sys_clk);
    slow <= 1'b1;
    for (int md = 1; md < 7; md++) begin
      wr_reg(8'h00, 32'(md));
      @(posedge sys_clk);
      run <= 1'b1;
      wait_stage(4'h5, n);
      @(posedge sys_clk);
      run <= 1'b0;
      cyc(3);
      check("stop idx", {28'h0, stage_idx}, 32'h5);
      check("stop auto", {31'h0, auto_on}, 32'h0);
      @(posedge sys_clk);
      run <= 1'b1;
      cyc(2);
      k = md < 4 ? 5 : 0;
      check("restart idx", {28'h0, stage_idx}, 32'(k));
      for (int s = k + 1; s < 16; s++) begin
        wait_stage(4'(s), n);
        if (s > k + 1) begin
          check("stage len", 32'(n), 32'(tv(s - 1)) * TC);
        end
        check("stage freq", {16'h0, freq_ref}, 32'(fv(s)));
        check("stage dir", {30'h0, dir}, 32'(dv(s)));
      end
      cyc(TC + 2);
      if (md % 3 == 1) begin
        check("done auto", {31'h0, auto_on}, 32'h0);
        check("done freq", {16'h0, freq_ref}, 32'h0);
      end else if (md % 3 == 2) begin
        check("loop idx", {28'h0, stage_idx}, 32'h0);
        check("loop auto", {31'h0, auto_on}, 32'h1);
      end else begin
        check("hold idx", {28'h0, stage_idx}, 32'hf);
        check("hold freq", {16'h0, freq_ref}, 32'(fv(15)));
        rd_reg(8'h01, rv);
        check("hold status", rv, 32'h221f);
      end
      @(posedge sys_clk);
      run <= 1'b0;
      cyc(3);
      $display("test mode %0d done", md);
    end
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h20 + 8'(i), 32'h0);
    end
    wr_reg(8'h00, 32'h2);
    @(posedge sys_clk);
    run <= 1'b1;
    cyc(3);
    check("zero times", {31'h0, auto_on}, 32'h0);
    $display("test zero times done");
    end_sim();
  end
endmodule : testbench
